/* File: src/jtl_jitter_ctrl.sv */
// Register file and control logic of the receive and transmit jitter attenuators.
//
// Operation
// - Receive reference clock divided by value plus one.
// - Receive smooth clock divided by value plus one.
// - Reference divisor write resets PLL, FIFO if tracking.
// - Output divisor write resets PLL, FIFO if tracking.
// - Reference divisor resets to 0x2f.
// - Output divisor resets to 0x2f.
// - Centring keeps pointer four UI from limits.
// - Centring runs 384 UI after set or slip.
// - Alarm inside window extends it, drops data.
// - Centring off: no steering, data passes.
// - Enabled overrun or underrun drives interrupt.
// - Phase tracking sends sync pulses to FIFO.
// - Limit bit nudges smooth clock near slip.
// - Transmit overrun flag set, cleared by read.
// - Transmit underrun flag set, cleared by read.
// - Transmit has its own reference divisor.
// - Map repeats for eight framers, 0x80 apart.
// - Receive status register with clear-on-read flags.
// - Transmit has its own output divisor.
`timescale 1ns/100ps

module jtl_jitter_ctrl
   import jtl_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH_UI = 64, // FIFO size in bit periods.
   parameter int unsigned NUM_ATT       = 2 * NUM_FRAMERS
)
(
   // Clock, reset and clock enable.
   input  wire logic                  core_clk_i,
   input  wire logic                  arst_n_i,
   input  wire logic                  ce_i,
   // Register port.
   input  wire logic [9:0]            addr_i,
   input  wire logic [7:0]            wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [7:0]            rdata_o,
   // Datapath, index is framer times two plus direction (0 rx, 1 tx).
   input  wire jtl_jat_in_t           jin_i  [NUM_ATT],
   output jtl_jat_out_t               jout_o [NUM_ATT],
   // Shared interrupt, active low.
   output logic                       irq_out_n_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------

   // Whole block state in one record so reset and enable act alike.
   typedef struct packed {
      jtl_jat_t [NUM_ATT-1:0] at;    // One record per attenuator.
      logic     [7:0]         rdata; // Read answer, one cycle wide.
      logic                   irq_n; // Registered interrupt line.
   } jtl_state_t;

   jtl_state_t state_ff;  // Registered state.
   jtl_state_t nxt_state; // Next state.

   // Fill thresholds, sized to the fill field.
   localparam logic [FILL_W-1:0] FULL_LVL   = FILL_W'(FIFO_DEPTH_UI);
   localparam logic [FILL_W-1:0] NEAR_FULL  = FILL_W'(FIFO_DEPTH_UI - LIMIT_MARGIN_UI);
   localparam logic [FILL_W-1:0] NEAR_EMPTY = FILL_W'(LIMIT_MARGIN_UI);
   localparam logic [FILL_W-1:0] CTR_HIGH   = FILL_W'(FIFO_DEPTH_UI - CENTRE_MARGIN_UI);
   localparam logic [FILL_W-1:0] CTR_LOW    = FILL_W'(CENTRE_MARGIN_UI);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   // The framer number sits above the 0x80 stride; the attenuator
   // registers occupy 0x10..0x13 and 0x18..0x1b of each window.
   logic       in_map;   // Address hits an attenuator register.
   logic [3:0] acc_idx;  // Attenuator addressed.
   logic [1:0] acc_sub;  // Register within that attenuator.

   always_comb
   begin
      in_map  = (addr_i[6:4] == RX_STATUS_OFS[6:4]) && !addr_i[2];
      acc_idx = {addr_i[9:7], addr_i[3]};
      acc_sub = addr_i[1:0];
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------

   // A plain loop rather than a generate keeps the state in a single
   // record, at the price of one wide combinational process.
   always_comb
   begin
      logic        sel;
      logic        wr_k;
      logic        rd_k;
      logic        full;
      logic        empty;
      logic        ovr_ev;
      logic        und_ev;
      logic        alarm;
      logic        restart;
      logic        self_centre_enable_set;
      logic        act;
      logic        irq_any;
      jtl_jat_in_t fi;
      jtl_jat_t    cur;
      sel      = 1'b0;
      wr_k     = 1'b0;
      rd_k     = 1'b0;
      full     = 1'b0;
      empty    = 1'b0;
      ovr_ev   = 1'b0;
      und_ev   = 1'b0;
      alarm    = 1'b0;
      restart  = 1'b0;
      self_centre_enable_set = 1'b0;
      act      = 1'b0;
      irq_any  = 1'b0;
      fi       = '0;
      cur      = '0;
      nxt_state       = state_ff;
      // Read data stand only in the cycle after the strobe.
      nxt_state.rdata = 8'h00;

      for (int k = 0; k < NUM_ATT; k++)
      begin
         cur  = state_ff.at[k];
         fi   = jin_i[k];
         sel  = in_map && (acc_idx == 4'(k));
         wr_k = wr_i && sel;
         rd_k = rd_i && sel;

         // FIFO conditions seen by this attenuator.
         full   = (fi.fill >= FULL_LVL);
         empty  = (fi.fill == '0);
         alarm  = full || empty;
         ovr_ev = fi.wr_try && full;
         und_ev = fi.rd_try && empty;

         // Pulses last one cycle unless raised again below.
         nxt_state.at[k].o.pll_rst    = 1'b0;
         nxt_state.at[k].o.fifo_rst   = 1'b0;
         nxt_state.at[k].o.pd_ref     = 1'b0;
         nxt_state.at[k].o.pd_out     = 1'b0;
         nxt_state.at[k].o.sync_pulse = 1'b0;
         restart  = 1'b0;
         self_centre_enable_set = 1'b0;

         // Register writes.
         if (wr_k)
         begin
            case (acc_sub)
               RX_REF_DIV_OFS[1:0]:
               begin
                  // Divisor change invalidates the PLL phase.
                  nxt_state.at[k].ref_div    = wdata_i;
                  restart                    = 1'b1;
                  nxt_state.at[k].o.fifo_rst = cur.cfg[CFG_SYNC_BIT];
               end
               RX_OUT_DIV_OFS[1:0]:
               begin
                  nxt_state.at[k].out_div    = wdata_i;
                  restart                    = 1'b1;
                  nxt_state.at[k].o.fifo_rst = cur.cfg[CFG_SYNC_BIT];
               end
               RX_CONFIG_OFS[1:0]:
               begin
                  // Bit 5 is stored as written and has no effect here.
                  nxt_state.at[k].cfg = wdata_i[5:0];
                  self_centre_enable_set            = wdata_i[CFG_SELF_CENTRE_ENABLE_BIT];
               end
               default:
               begin
                  // The status register ignores writes.
                  restart = 1'b0;
               end
            endcase
         end
         nxt_state.at[k].o.pll_rst = restart;

         // Register reads; status flags are returned before clearing.
         if (rd_k)
         begin
            case (acc_sub)
               RX_STATUS_OFS[1:0]:
               begin
                  nxt_state.rdata[STS_OVR_BIT] = cur.ovr;
                  nxt_state.rdata[STS_UND_BIT] = cur.und;
               end
               RX_REF_DIV_OFS[1:0]:
               begin
                  nxt_state.rdata = cur.ref_div;
               end
               RX_OUT_DIV_OFS[1:0]:
               begin
                  nxt_state.rdata = cur.out_div;
               end
               default:
               begin
                  nxt_state.rdata = {2'b00, cur.cfg};
               end
            endcase
         end

         // Sticky flags: a new event in the read cycle survives the clear.
         if (rd_k && acc_sub == RX_STATUS_OFS[1:0])
         begin
            nxt_state.at[k].ovr = ovr_ev;
            nxt_state.at[k].und = und_ev;
         end
         else
         begin
            nxt_state.at[k].ovr = cur.ovr || ovr_ev;
            nxt_state.at[k].und = cur.und || und_ev;
         end

         // Reference divider: one discriminator pulse per value plus one.
         if (restart)
         begin
            nxt_state.at[k].ref_cnt = 8'h00;
         end
         else if (fi.ref_tick)
         begin
            if (cur.ref_cnt >= cur.ref_div)
            begin
               nxt_state.at[k].ref_cnt  = 8'h00;
               nxt_state.at[k].o.pd_ref = 1'b1;
            end
            else
            begin
               nxt_state.at[k].ref_cnt = cur.ref_cnt + 8'h01;
            end
         end

         // Output divider on the smooth clock, built the same way.
         if (restart)
         begin
            nxt_state.at[k].out_cnt = 8'h00;
         end
         else if (fi.out_tick)
         begin
            if (cur.out_cnt >= cur.out_div)
            begin
               nxt_state.at[k].out_cnt  = 8'h00;
               nxt_state.at[k].o.pd_out = 1'b1;
               // Phase tracking aligns the FIFO once per compare.
               nxt_state.at[k].o.sync_pulse = cur.cfg[CFG_SYNC_BIT];
            end
            else
            begin
               nxt_state.at[k].out_cnt = cur.out_cnt + 8'h01;
            end
         end

         // Centring window: loaded on set or slip, frozen by alarms.
         if (!nxt_state.at[k].cfg[CFG_SELF_CENTRE_ENABLE_BIT])
         begin
            nxt_state.at[k].self_centre_enable_cnt = 9'h000;
         end
         else if (self_centre_enable_set || ovr_ev || und_ev)
         begin
            nxt_state.at[k].self_centre_enable_cnt = SELF_CENTRE_ENABLE_WINDOW_UI;
         end
         else if (fi.ui_tick && !alarm && cur.self_centre_enable_cnt != 9'h000)
         begin
            // An alarm holds the count, lengthening the window.
            nxt_state.at[k].self_centre_enable_cnt = cur.self_centre_enable_cnt - 9'h001;
         end

         // Steering and discard only while the window is open.
         act = nxt_state.at[k].cfg[CFG_SELF_CENTRE_ENABLE_BIT] && (nxt_state.at[k].self_centre_enable_cnt != 9'h000);
         nxt_state.at[k].o.centre_act = act;
         nxt_state.at[k].o.steer_hold = act && (fi.fill < CTR_LOW);
         nxt_state.at[k].o.steer_skip = act && (fi.fill > CTR_HIGH);
         nxt_state.at[k].o.discard    = act && alarm;

         // Limit mode bends the smooth clock one UI from a slip.
         nxt_state.at[k].o.clk_faster = nxt_state.at[k].cfg[CFG_LIMIT_BIT] &&
                                        (fi.fill >= NEAR_FULL);
         nxt_state.at[k].o.clk_slower = nxt_state.at[k].cfg[CFG_LIMIT_BIT] &&
                                        (fi.fill <= NEAR_EMPTY);

         // Only enabled flags may pull the interrupt line.
         irq_any = irq_any ||
                   (nxt_state.at[k].ovr && nxt_state.at[k].cfg[CFG_OVR_IRQ_BIT]) ||
                   (nxt_state.at[k].und && nxt_state.at[k].cfg[CFG_UND_IRQ_BIT]);
      end

      nxt_state.irq_n = !irq_any;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // The clock enable freezes every flop, pulses included.
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         for (int k = 0; k < NUM_ATT; k++)
         begin
            state_ff.at[k] <= JAT_RST;
         end
         state_ff.rdata <= 8'h00;
         state_ff.irq_n <= 1'b1;
      end
      else if (ce_i)
      begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------

   always_comb
   begin
      rdata_o     = state_ff.rdata;
      irq_out_n_o = state_ff.irq_n;
      for (int k = 0; k < NUM_ATT; k++)
      begin
         jout_o[k] = state_ff.at[k].o;
      end
   end

endmodule : jtl_jitter_ctrl

/* File: src/jtl_pkg.sv */
// Package for the jitter attenuator control block: map, fields, resets, carriers.
package jtl_pkg;

   // ----------------------------------------------------------------
   // Register map (offset inside one framer window, 0x80 stride)
   // ----------------------------------------------------------------
   localparam logic [6:0] RX_STATUS_OFS  = 7'h10; // Receive interrupt status.
   localparam logic [6:0] RX_REF_DIV_OFS = 7'h11; // Receive reference divisor.
   localparam logic [6:0] RX_OUT_DIV_OFS = 7'h12; // Receive output divisor.
   localparam logic [6:0] RX_CONFIG_OFS  = 7'h13; // Receive configuration.
   localparam logic [6:0] TX_STATUS_OFS  = 7'h18; // Transmit interrupt status.
   localparam logic [6:0] TX_REF_DIV_OFS = 7'h19; // Transmit reference divisor.
   localparam logic [6:0] TX_OUT_DIV_OFS = 7'h1a; // Transmit output divisor.
   localparam logic [6:0] TX_CONFIG_OFS  = 7'h1b; // Transmit configuration.
   localparam int         FRAMER_STRIDE  = 32'h80; // Byte spacing of framers.
   localparam int         NUM_FRAMERS    = 8;      // Framer copies of the map.

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CFG_LIMIT_BIT    = 0; // Limit jitter attenuation near slip.
   localparam int CFG_SYNC_BIT     = 1; // Phase-tracking enable.
   localparam int CFG_OVR_IRQ_BIT  = 2; // overrun_irq_enable.
   localparam int CFG_UND_IRQ_BIT  = 3; // underrun_irq_enable.
   localparam int CFG_SELF_CENTRE_ENABLE_BIT     = 4; // self_centre_enable.
   localparam int STS_UND_BIT      = 0; // underrun_flag.
   localparam int STS_OVR_BIT      = 1; // overrun_flag.

   // ----------------------------------------------------------------
   // Reset values and timing counts (in unit intervals)
   // ----------------------------------------------------------------
   localparam logic [7:0] REF_DIV_RST      = 8'h2f;
   localparam logic [7:0] OUT_DIV_RST      = 8'h2f;
   localparam logic [5:0] CONFIG_RST       = 6'h23;
   localparam logic [8:0] SELF_CENTRE_ENABLE_WINDOW_UI   = 9'h180; // 384 bit periods.
   localparam int         CENTRE_MARGIN_UI = 4;
   localparam int         LIMIT_MARGIN_UI  = 1;
   localparam int         FILL_W           = 8;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Datapath view of one attenuator, all strobes one clock wide.
   typedef struct packed {
      logic              ui_tick;  // One bit period elapsed.
      logic              ref_tick; // Edge of the PLL reference clock.
      logic              out_tick; // Edge of the smooth output clock.
      logic              wr_try;   // FIFO write attempt.
      logic              rd_try;   // FIFO read attempt.
      logic [FILL_W-1:0] fill;     // FIFO fill level in UI.
   } jtl_jat_in_t;

   // Controls returned to the datapath for one attenuator.
   typedef struct packed {
      logic pll_rst;     // Pulse: restart the PLL.
      logic fifo_rst;    // Pulse: restart the FIFO pointers.
      logic pd_ref;      // Pulse: divided reference to phase discriminator.
      logic pd_out;      // Pulse: divided smooth clock to phase discriminator.
      logic sync_pulse;  // Pulse: align FIFO delay to the PLL lag.
      logic centre_act;  // Level: self-centring window open.
      logic steer_hold;  // Level: hold read pointer, too close to empty.
      logic steer_skip;  // Level: advance read pointer, too close to full.
      logic discard;     // Level: data dropped during an alarm.
      logic clk_faster;  // Level: raise smooth clock, near overflow.
      logic clk_slower;  // Level: lower smooth clock, near underflow.
   } jtl_jat_out_t;

   // Full state of one attenuator.
   typedef struct packed {
      logic [7:0]   ref_div;  // ref_divisor_minus_one.
      logic [7:0]   out_div;  // out_divisor_minus_one.
      logic [5:0]   cfg;      // Configuration bits 5..0.
      logic         ovr;      // overrun_flag.
      logic         und;      // underrun_flag.
      logic [7:0]   ref_cnt;  // Reference divider count.
      logic [7:0]   out_cnt;  // Output divider count.
      logic [8:0]   self_centre_enable_cnt; // UI left in the centring window.
      jtl_jat_out_t o;        // Registered controls.
   } jtl_jat_t;

   localparam jtl_jat_t JAT_RST = '{ref_div: REF_DIV_RST, out_div: OUT_DIV_RST,
                                    cfg: CONFIG_RST, default: '0};

endpackage : jtl_pkg

/* File: tb/jtl_dp_model.sv */
// Behavioural framer datapath that feeds the attenuator status inputs.
`timescale 1ns/100ps
module jtl_dp_model
   import jtl_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Commands from the bench.
   input  wire logic [3:0] idx_i,
   input  wire logic [7:0] fill_i,
   input  wire logic       tick_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   // Datapath view of every attenuator.
   output jtl_jat_in_t     jin_o [2*NUM_FRAMERS]
);
   // Only the selected attenuator moves; the rest idle half full, so that
   // no stray alarm or slip disturbs their flags.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      for (int i = 0; i < 2*NUM_FRAMERS; i++)
      begin
         if (!rst_n_i)
            jin_o[i] <= '{fill: 8'h20, default: '0};
         else if (4'(i) == idx_i)
            jin_o[i] <= '{ui_tick: tick_i, ref_tick: tick_i, out_tick: tick_i,
                          wr_try: wr_i, rd_try: rd_i, fill: fill_i};
         else
            jin_o[i] <= '{fill: 8'h20, default: '0};
      end
   end
endmodule : jtl_dp_model

/* File: tb/jtl_jitter_ctrl_asserts.sv */
// Port-level assertions of the jitter attenuator control block.
`timescale 1ns/100ps
module jtl_chk
   import jtl_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH_UI = 64,
   parameter int unsigned NUM_ATT       = 2 * NUM_FRAMERS
)
(
   // Watched ports.
   input wire logic         core_clk_i,
   input wire logic         arst_n_i,
   input wire logic         ce_i,
   input wire logic [9:0]   addr_i,
   input wire logic [7:0]   wdata_i,
   input wire logic         wr_i,
   input wire logic         rd_i,
   input wire logic [7:0]   rdata_o,
   input wire jtl_jat_in_t  jin_i  [NUM_ATT],
   input wire jtl_jat_out_t jout_o [NUM_ATT],
   input wire logic         irq_out_n_o
);
   // Apart from a config write that masks the flag, a status read of any attenuator is the only thing that may release the interrupt.
   wire logic sts_rd = rd_i && ce_i &&
                       (addr_i[6:0] == RX_STATUS_OFS || addr_i[6:0] == TX_STATUS_OFS);
   wire logic wr_f0  = wr_i && ce_i && addr_i[9:7] == 3'h0; // Write into framer 0.

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   AST_RD_IDLE: assert property (!$past(rd_i && ce_i) |-> rdata_o == 8'h00)
      else $error("read data outside its slot");
   AST_REF_WR_RST: assert property (wr_f0 && addr_i[6:0] == RX_REF_DIV_OFS |=> jout_o[0].pll_rst)
      else $error("reference divisor write gave no PLL restart");
   AST_OUT_WR_RST: assert property (wr_f0 && addr_i[6:0] == RX_OUT_DIV_OFS |=> jout_o[0].pll_rst)
      else $error("output divisor write gave no PLL restart");
   AST_TX_WR_RST: assert property (wr_f0 && addr_i[6:0] == TX_REF_DIV_OFS |=> jout_o[1].pll_rst)
      else $error("transmit divisor write gave no PLL restart");
   AST_RST_CAUSE: assert property (jout_o[0].pll_rst |-> $past(wr_f0 &&
      (addr_i[6:0] == RX_REF_DIV_OFS || addr_i[6:0] == RX_OUT_DIV_OFS)))
      else $error("PLL restart without divisor write");
   AST_PD_REF: assert property (jout_o[0].pd_ref |-> $past(jin_i[0].ref_tick))
      else $error("divided reference without reference tick");
   AST_SYNC_PD: assert property (jout_o[0].sync_pulse |-> jout_o[0].pd_out)
      else $error("sync pulse apart from divided smooth clock");
   AST_IRQ_HOLD: assert property (!irq_out_n_o && !sts_rd |=> !irq_out_n_o)
      else $error("interrupt released without status read");
   AST_IRQ_RISE: assert property ($rose(irq_out_n_o) |-> $past(sts_rd))
      else $error("interrupt rose without status read");
   AST_LIM_FAST: assert property (jout_o[0].clk_faster |->
      $past(jin_i[0].fill) >= 8'(FIFO_DEPTH_UI - 1))
      else $error("clock raised away from overflow");
   AST_LIM_SLOW: assert property (jout_o[0].clk_slower |-> $past(jin_i[0].fill) <= 8'h01)
      else $error("clock lowered away from underflow");
   AST_STEER: assert property (jout_o[0].steer_hold |->
      $past(jin_i[0].fill) < 8'(CENTRE_MARGIN_UI))
      else $error("pointer held outside the margin");
endmodule : jtl_chk

bind jtl_jitter_ctrl jtl_chk #(.FIFO_DEPTH_UI(FIFO_DEPTH_UI), .NUM_ATT(NUM_ATT)) chk_u (
   .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .jin_i(jin_i),
   .jout_o(jout_o), .irq_out_n_o(irq_out_n_o));

/* File: tb/jtl_jitter_ctrl_test.sv */
// Self-checking testbench of the jitter attenuator control block.
`timescale 1ns/100ps
module jtl_jitter_ctrl_test;
   import jtl_pkg::*;
   localparam int unsigned DEP = 64; // FIFO depth handed to the block.
   logic         clk, rst_n, ce;     // Clock, reset, clock enable (held high).
   logic [9:0]   addr;               // Register address.
   logic [7:0]   wdata, rdata;       // Register data.
   logic         wr, rd, irq_n;      // Strobes and interrupt.
   jtl_jat_in_t  jin  [2*NUM_FRAMERS]; // Model to block.
   jtl_jat_out_t jout [2*NUM_FRAMERS]; // Block to bench.
   logic [3:0]   m_idx;              // Attenuator the model drives.
   logic [7:0]   m_fill;             // Fill level reported.
   logic         m_tick, m_wr, m_rd; // Model commands.
   int           n_mismatch, n_checks;

   jtl_jitter_ctrl #(.FIFO_DEPTH_UI(DEP)) dut_u (.core_clk_i(clk), .arst_n_i(rst_n),
      .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .jin_i(jin), .jout_o(jout), .irq_out_n_o(irq_n));
   jtl_dp_model model_u (.clk_i(clk), .rst_n_i(rst_n), .idx_i(m_idx), .fill_i(m_fill),
      .tick_i(m_tick), .wr_i(m_wr), .rd_i(m_rd), .jin_o(jin));

   // 40 MHz core clock.
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // Byte address of an offset in one framer window.
   function automatic logic [9:0] ad(input int f, input logic [6:0] o);
      return {3'(f), o};
   endfunction : ad

   // Counts a comparison and reports a mismatch at once.
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One-cycle write; returns just after the taking edge so pulses can be seen.
   task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      #1;
   endtask : reg_wr

   // One-cycle read; data are taken in the only cycle they stand.
   task automatic rd_chk(input string what, input logic [9:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      check(what, {8'h00, e}, {8'h00, rdata});
   endtask : rd_chk

   // Model reports a fill level with optional FIFO attempts, then settles.
   task automatic fifo_op(input logic [7:0] f, input logic w, input logic r);
      @(posedge clk);
      m_fill <= f;
      m_wr   <= w;
      m_rd   <= r;
      @(posedge clk);
      m_wr   <= 1'b0;
      m_rd   <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : fifo_op

   // Reset values on the first and last framer, and an unmapped place.
   task automatic t_reset();
      for (int f = 0; f < NUM_FRAMERS; f += 7)
      begin
         rd_chk("rx ref div", ad(f, RX_REF_DIV_OFS), 8'h2f);
         rd_chk("rx out div", ad(f, RX_OUT_DIV_OFS), 8'h2f);
         rd_chk("rx config", ad(f, RX_CONFIG_OFS), 8'h23);
         rd_chk("tx ref div", ad(f, TX_REF_DIV_OFS), 8'h2f);
         rd_chk("tx out div", ad(f, TX_OUT_DIV_OFS), 8'h2f);
         rd_chk("rx status", ad(f, RX_STATUS_OFS), 8'h00);
         rd_chk("tx status", ad(f, TX_STATUS_OFS), 8'h00);
         rd_chk("unmapped", ad(f, 7'h14), 8'h00);
      end
   endtask : t_reset

   // Divisor writes restart PLL and, with tracking on, the FIFO; framers stay apart.
   task automatic t_stride();
      reg_wr(ad(3, RX_REF_DIV_OFS), 8'h5f);
      check("pll_rst", 1, jout[6].pll_rst);
      check("fifo_rst", 1, jout[6].fifo_rst);
      rd_chk("ref div f3", ad(3, RX_REF_DIV_OFS), 8'h5f);
      rd_chk("ref div f2", ad(2, RX_REF_DIV_OFS), 8'h2f);
      reg_wr(ad(3, RX_CONFIG_OFS), 8'h21);
      reg_wr(ad(3, RX_OUT_DIV_OFS), 8'h3a);
      check("pll_rst", 1, jout[6].pll_rst);
      check("fifo_rst", 0, jout[6].fifo_rst);
      reg_wr(ad(0, TX_REF_DIV_OFS), 8'h2f);
      check("tx pll_rst", 1, jout[1].pll_rst);
   endtask : t_stride

   // Sends k ticks to attenuator 0 and counts the divided pulses.
   task automatic ticks(input int k, input logic [15:0] er, input logic [15:0] eo,
                        input logic [15:0] es);
      logic [15:0] cr, co, cs;
      cr = 0;
      co = 0;
      cs = 0;
      for (int i = 0; i < k + 6; i++)
      begin
         @(posedge clk);
         if (i == 0) m_tick <= 1'b1;
         if (i == k) m_tick <= 1'b0;
         #1;
         cr += 16'(jout[0].pd_ref);
         co += 16'(jout[0].pd_out);
         cs += 16'(jout[0].sync_pulse);
      end
      check("pd_ref count", er, cr);
      check("pd_out count", eo, co);
      check("sync count", es, cs);
   endtask : ticks

   // Reset divisors of 48, then divide by three and four with tracking off.
   task automatic t_divide();
      ticks(60, 1, 1, 1);
      reg_wr(ad(0, RX_CONFIG_OFS), 8'h21);
      reg_wr(ad(0, RX_REF_DIV_OFS), 8'h02);
      reg_wr(ad(0, RX_OUT_DIV_OFS), 8'h03);
      ticks(12, 4, 3, 0);
   endtask : t_divide

   // Overrun and underrun in both directions: flags, masking, clear on read.
   task automatic t_flags();
      for (int d = 0; d < 2; d++)
      begin
         m_idx <= 4'(d);
         reg_wr(ad(0, d ? TX_CONFIG_OFS : RX_CONFIG_OFS), 8'h24);
         fifo_op(8'(DEP), 1'b1, 1'b0);
         fifo_op(8'h00, 1'b0, 1'b1);
         check("no discard", 0, jout[d].discard);
         check("irq set", 0, irq_n);
         rd_chk("both flags", ad(0, d ? TX_STATUS_OFS : RX_STATUS_OFS), 8'h03);
         check("irq released", 1, irq_n);
         rd_chk("cleared", ad(0, d ? TX_STATUS_OFS : RX_STATUS_OFS), 8'h00);
         fifo_op(8'h00, 1'b0, 1'b1);
         check("irq masked", 1, irq_n);
         rd_chk("underrun", ad(0, d ? TX_STATUS_OFS : RX_STATUS_OFS), 8'h01);
         fifo_op(8'h20, 1'b0, 1'b0);
      end
      m_idx <= 4'h0;
   endtask : t_flags

   // Centring window of 384 UI, lengthened by a 10 UI empty alarm.
   task automatic t_centre();
      int len;
      len = 0;
      fifo_op(8'h02, 1'b0, 1'b0);
      m_tick <= 1'b1;
      reg_wr(ad(0, RX_CONFIG_OFS), 8'h30);
      for (int n = 0; n < 500 && len == 0; n++)
      begin
         @(posedge clk);
         if (n == 100) m_fill <= 8'h00;
         if (n == 110) m_fill <= 8'h3e;
         #1;
         if (n == 3) check("steer_hold", 1, jout[0].steer_hold);
         if (n == 105) check("discard", 1, jout[0].discard);
         if (n == 115) check("steer_skip", 1, jout[0].steer_skip);
         if (jout[0].centre_act !== 1'b1) len = n;
      end
      check("window", 1, len >= 391 && len <= 397);
      check("no steer", 0, jout[0].steer_skip);
      m_tick <= 1'b0;
   endtask : t_centre

   // Limit bit nudges the smooth clock one UI from either slip.
   task automatic t_limit();
      reg_wr(ad(0, RX_CONFIG_OFS), 8'h21);
      fifo_op(8'(DEP - 1), 1'b0, 1'b0);
      check("faster", 1, jout[0].clk_faster);
      fifo_op(8'h01, 1'b0, 1'b0);
      check("slower", 1, jout[0].clk_slower);
      reg_wr(ad(0, RX_CONFIG_OFS), 8'h20);
      fifo_op(8'h01, 1'b0, 1'b0);
      check("free", 0, jout[0].clk_slower);
   endtask : t_limit

   // Prints the verdict and ends the run.
   task automatic print_verdict();
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // Main sequence: reset, then every scenario.
   initial
   begin
      {rst_n, addr, wdata, wr, rd, m_idx, m_tick, m_wr, m_rd} = '0;
      ce         = 1'b1;
      m_fill     = 8'h20;
      n_mismatch = 0;
      n_checks   = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_stride();
      t_divide();
      t_flags();
      t_centre();
      t_limit();
      print_verdict();
   end

   // Watchdog, well past the scenarios' length.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
endmodule : jtl_jitter_ctrl_test
